// ==== core/vch_host_reg_port.sv ====
`timescale 1ns/1ps
module vch_host_reg_port #(
    parameter int DP_COUNT = vch_pkg::DP_COUNT
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [vch_pkg::ADDR_W-1:0] hostAddr,
    input wire logic hostWrite,
    input wire logic hostRead,
    input wire logic [vch_pkg::WORD_W-1:0] hostWrData,
    output logic [vch_pkg::WORD_W-1:0] hostRdData,
    output logic hostRdValid,
    input wire logic [vch_pkg::BYTE_W-1:0] pixelIn,
    input wire logic pixelValid,
    output logic [vch_pkg::WORD_W-1:0] colourOut,
    output logic colourValid,
    output logic videoTimingEnable,
    output logic hostByteMode,
    output logic mode2Select,
    output logic [vch_pkg::WORD_W-1:0] pllMultiplier,
    output logic bootWritten
);
    localparam int DP_IW = (DP_COUNT > 1) ? $clog2(DP_COUNT) : 1;

    // Register targets inside the half kilo-word block
    typedef enum logic [2:0] {
        TGT_NONE,
        TGT_PAL,
        TGT_BOOT,
        TGT_DP,
        TGT_MASK,
        TGT_CTRL
    } vch_target_t;

    typedef struct packed {
        // Host-visible registers
        logic [vch_pkg::WORD_W-1:0] control;
        logic [vch_pkg::BYTE_W-1:0] mask;
        logic [vch_pkg::WORD_W-1:0] boot;
        logic bootDone;
        logic anyWrite;
        logic [DP_COUNT-1:0][vch_pkg::WORD_W-1:0] dataPath;
        // Read pipeline
        logic rdPend;
        logic rdIsPal;
        logic rdByteMode;
        logic [1:0] rdByteSel;
        logic [vch_pkg::WORD_W-1:0] rdRegWord;
        logic [vch_pkg::WORD_W-1:0] rdData;
        logic rdValid;
        // Pixel pipeline
        logic pixPend;
    } vch_port_state_t;

    vch_port_state_t st;
    vch_port_state_t next_st;

    // Byte sequencer results
    logic seqCommit;
    logic [vch_pkg::WORD_W-1:0] seqData;
    logic [1:0] seqByteSel;

    // Palette ports
    logic palWrEn;
    logic [vch_pkg::WORD_W-1:0] palHostRd;
    logic [vch_pkg::WORD_W-1:0] palPixRd;
    logic [vch_pkg::BYTE_W-1:0] lookupIndex;

    // Address decode and read path
    vch_target_t target;
    logic [DP_IW-1:0] dpSel;
    logic [vch_pkg::WORD_W-1:0] regWord;
    logic [vch_pkg::WORD_W-1:0] selWord;
    logic [vch_pkg::BYTE_W-1:0] selByte;

    // Palette occupies the lower half of the block
    function automatic logic isPalette(
        input logic [vch_pkg::ADDR_W-1:0] a
    );
        isPalette = (a[vch_pkg::ADDR_W-1] == 1'b0);
    endfunction

    // True for the data path register window
    function automatic logic isDataPath(
        input logic [vch_pkg::ADDR_W-1:0] a
    );
        isDataPath = (a >= vch_pkg::DP_BASE)
            && (a < vch_pkg::DP_BASE + DP_COUNT[vch_pkg::ADDR_W-1:0]);
    endfunction

    // Index of a data path register from its word address
    function automatic logic [DP_IW-1:0] dpIndex(
        input logic [vch_pkg::ADDR_W-1:0] a
    );
        logic [vch_pkg::ADDR_W-1:0] off;
        off = a - vch_pkg::DP_BASE;
        dpIndex = off[DP_IW-1:0];
    endfunction

    // Which register a word address selects; the rest is unmapped
    function automatic vch_target_t decodeTarget(
        input logic [vch_pkg::ADDR_W-1:0] a
    );
        if (isPalette(a)) begin
            decodeTarget = TGT_PAL;
        end else if (a == vch_pkg::CTRL_ADDR) begin
            decodeTarget = TGT_CTRL;
        end else if (a == vch_pkg::MASK_ADDR) begin
            decodeTarget = TGT_MASK;
        end else if (a == vch_pkg::BOOT_ADDR) begin
            decodeTarget = TGT_BOOT;
        end else if (isDataPath(a)) begin
            decodeTarget = TGT_DP;
        end else begin
            decodeTarget = TGT_NONE;
        end
    endfunction

    // Byte mode follows control bit 7, word mode when clear
    assign hostByteMode = st.control[vch_pkg::CTRL_BYTE_BIT];
    assign videoTimingEnable = st.control[vch_pkg::CTRL_VTG_BIT];
    assign mode2Select = st.control[vch_pkg::CTRL_MODE2_BIT];
    assign pllMultiplier = st.boot;
    assign bootWritten = st.bootDone;
    assign hostRdData = st.rdData;
    assign hostRdValid = st.rdValid;
    assign colourOut = palPixRd;
    assign colourValid = st.pixPend;

    // One decode serves the read mux and the write path alike
    assign target = decodeTarget(hostAddr);
    assign dpSel = dpIndex(hostAddr);

    // Shared byte counter; address change restarts it
    // Reads and writes share it, so a direction change restarts it too
    vch_byte_seq u_seq (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .byteMode(hostByteMode),
        .hostWrite(hostWrite),
        .hostRead(hostRead & ~hostWrite),
        .hostAddr(hostAddr),
        .hostWrData(hostWrData),
        .commit(seqCommit),
        .commitData(seqData),
        .byteSel(seqByteSel)
    );

    // Mode 1 masks the pixel before it indexes the table
    always_comb begin
        if (mode2Select) begin
            lookupIndex = pixelIn;
        end else begin
            lookupIndex = pixelIn & st.mask;
        end
    end

    // The palette takes host writes at any time; glitches are the host's
    assign palWrEn = seqCommit && isPalette(hostAddr);

    // Separate pixel and host read ports, so neither waits on the other
    vch_palette_ram #(
        .DEPTH(vch_pkg::PAL_DEPTH),
        .AW(vch_pkg::PAL_AW),
        .DW(vch_pkg::WORD_W)
    ) u_palette (
        .ref_clk(ref_clk),
        .wrEn(palWrEn),
        .wrAddr(hostAddr[vch_pkg::PAL_AW-1:0]),
        .wrData(seqData),
        .hostRdAddr(hostAddr[vch_pkg::PAL_AW-1:0]),
        .hostRdData(palHostRd),
        .pixRdAddr(lookupIndex),
        .pixRdData(palPixRd)
    );

    // Register read mux; unmapped words read as zero
    // Captured at the request edge, so a later write cannot leak in
    always_comb begin
        unique case (target)
            TGT_CTRL: begin
                regWord = st.control;
            end
            TGT_MASK: begin
                regWord = {16'h0000, st.mask};
            end
            TGT_BOOT: begin
                regWord = st.boot;
            end
            TGT_DP: begin
                regWord = st.dataPath[dpSel];
            end
            default: begin
                // Palette words come from the table, not this mux
                regWord = vch_pkg::UNMAPPED_READ;
            end
        endcase
    end

    // Second read stage picks the source, then the byte lane
    always_comb begin
        selWord = st.rdIsPal ? palHostRd : st.rdRegWord;
        unique case (st.rdByteSel)
            2'h0: selByte = selWord[7:0];
            2'h1: selByte = selWord[15:8];
            default: selByte = selWord[23:16];
        endcase
    end

    // Next-state logic for the whole port
    always_comb begin
        next_st = st;
        next_st.rdValid = 1'b0;
        next_st.rdPend = 1'b0;
        next_st.pixPend = pixelValid;

        // Read request: capture source and byte lane, answer two edges on
        // A write in the same cycle wins and the read is dropped
        if (hostRead && !hostWrite) begin
            next_st.rdPend = 1'b1;
            next_st.rdIsPal = isPalette(hostAddr);
            next_st.rdRegWord = regWord;
            next_st.rdByteMode = hostByteMode;
            next_st.rdByteSel = seqByteSel;
        end
        if (st.rdPend) begin
            next_st.rdValid = 1'b1;
            if (st.rdByteMode) begin
                next_st.rdData = {16'h0000, selByte};
            end else begin
                next_st.rdData = selWord;
            end
        end

        // Committed writes: full words only, whatever the host width
        if (seqCommit) begin
            next_st.anyWrite = 1'b1;
            unique case (target)
                TGT_CTRL: begin
                    next_st.control = seqData;
                end
                TGT_MASK: begin
                    next_st.mask = seqData[7:0];
                end
                TGT_BOOT: begin
                    // Only the first write after reset reaches it
                    if (!st.anyWrite && !st.bootDone) begin
                        next_st.boot = seqData;
                        next_st.bootDone = 1'b1;
                    end
                end
                TGT_DP: begin
                    // Zero is stored; keeping it non-zero is the host's
                    next_st.dataPath[dpSel] = seqData;
                end
                default: begin
                    // Palette writes go to the table; others are dropped
                end
            endcase
        end

        // Reset: generator off, word mode, boot unlocked; tables kept
        // Mask and data path hold across reset on purpose
        if (sys_rst) begin
            next_st.control = vch_pkg::CTRL_RESET;
            next_st.bootDone = 1'b0;
            next_st.anyWrite = 1'b0;
            next_st.rdPend = 1'b0;
            next_st.rdValid = 1'b0;
            next_st.rdIsPal = 1'b0;
            next_st.rdByteMode = 1'b0;
            next_st.rdByteSel = 2'h0;
            next_st.rdRegWord = vch_pkg::RD_RESET;
            next_st.rdData = vch_pkg::RD_RESET;
            next_st.pixPend = 1'b0;
        end
    end

    // State register; data path, mask and boot value keep across reset
    // No reset term here: retention is settled in the next-state logic
    always_ff @(posedge ref_clk) begin
        st <= next_st;
    end
endmodule // vch_host_reg_port

// ==== core/vch_pkg.sv ====
package vch_pkg;
    // Host word and byte geometry
    localparam int ADDR_W = 9;
    localparam int WORD_W = 24;
    localparam int BYTE_W = 8;
    localparam int BYTES_PER_WORD = 3;
    localparam logic [1:0] LAST_BYTE_IDX = 2'h2;

    // Colour lookup table geometry
    localparam int PAL_DEPTH = 256;
    localparam int PAL_AW = 8;

    // Word addresses inside the half kilo-word block
    localparam logic [ADDR_W-1:0] PAL_BASE = 9'h000;
    localparam logic [ADDR_W-1:0] BOOT_ADDR = 9'h100;
    localparam logic [ADDR_W-1:0] DP_BASE = 9'h101;
    localparam int DP_COUNT = 16;
    localparam logic [ADDR_W-1:0] MASK_ADDR = 9'h120;
    localparam logic [ADDR_W-1:0] CTRL_ADDR = 9'h160;

    // Control word fields
    localparam int CTRL_VTG_BIT = 0;
    localparam int CTRL_MODE2_BIT = 1;
    localparam int CTRL_BYTE_BIT = 7;

    // Reset values
    localparam logic [WORD_W-1:0] CTRL_RESET = 24'h000000;
    localparam logic [WORD_W-1:0] RD_RESET = 24'h000000;
    localparam logic [WORD_W-1:0] UNMAPPED_READ = 24'h000000;
endpackage

// ==== core/vch_palette_ram.sv ====
`timescale 1ns/1ps
// Colour lookup table: one write port, two registered read ports
module vch_palette_ram #(
    parameter int DEPTH = vch_pkg::PAL_DEPTH,
    parameter int AW = vch_pkg::PAL_AW,
    parameter int DW = vch_pkg::WORD_W
) (
    input wire logic ref_clk,
    input wire logic wrEn,
    input wire logic [AW-1:0] wrAddr,
    input wire logic [DW-1:0] wrData,
    input wire logic [AW-1:0] hostRdAddr,
    output logic [DW-1:0] hostRdData,
    input wire logic [AW-1:0] pixRdAddr,
    output logic [DW-1:0] pixRdData
);
    logic [DW-1:0] mem [DEPTH];

    // No reset: contents survive a device reset
    always_ff @(posedge ref_clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
        hostRdData <= mem[hostRdAddr];
        pixRdData <= mem[pixRdAddr];
    end
endmodule // vch_palette_ram

// ==== core/vch_byte_seq.sv ====
`timescale 1ns/1ps
// Assembles byte-mode writes into words and tracks byte-mode read order
module vch_byte_seq (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic byteMode,
    input wire logic hostWrite,
    input wire logic hostRead,
    input wire logic [vch_pkg::ADDR_W-1:0] hostAddr,
    input wire logic [vch_pkg::WORD_W-1:0] hostWrData,
    output logic commit,
    output logic [vch_pkg::WORD_W-1:0] commitData,
    output logic [1:0] byteSel
);
    typedef struct packed {
        logic [1:0] count;
        logic [vch_pkg::ADDR_W-1:0] lastAddr;
        logic lastWrite;
        logic [2*vch_pkg::BYTE_W-1:0] assembled;
    } vch_seq_state_t;

    vch_seq_state_t st;
    vch_seq_state_t next_st;
    logic access;
    logic sameSeq;
    logic [1:0] idx;

    // A sequence continues only at the same address and direction
    always_comb begin
        next_st = st;
        access = hostWrite | hostRead;
        sameSeq = (st.count != 2'h0) && (hostAddr == st.lastAddr)
            && (st.lastWrite == hostWrite);
        idx = sameSeq ? st.count : 2'h0;
        commit = 1'b0;
        commitData = hostWrData;
        byteSel = idx;
        if (access) begin
            next_st.lastAddr = hostAddr;
            next_st.lastWrite = hostWrite;
            if (!byteMode) begin
                commit = hostWrite;
                next_st.count = 2'h0;
            end else begin
                // Low byte first; nothing is stored until the third byte
                next_st.count = (idx == vch_pkg::LAST_BYTE_IDX) ? 2'h0
                    : idx + 2'h1;
                if (hostWrite) begin
                    unique case (idx)
                        2'h0: next_st.assembled[7:0] = hostWrData[7:0];
                        2'h1: next_st.assembled[15:8] = hostWrData[7:0];
                        default: begin
                            commit = 1'b1;
                            commitData = {hostWrData[7:0], st.assembled};
                        end
                    endcase
                end
            end
        end
        if (sys_rst) begin
            next_st.count = 2'h0;
        end
    end

    // State register
    always_ff @(posedge ref_clk) begin
        st <= next_st;
    end
endmodule // vch_byte_seq

// ==== tb/vch_host_model.sv ====
`timescale 1ns/1ps
// Host processor model; idle lines show the inverse of the last value
module vch_host_model (
    input wire logic ref_clk,
    output logic [8:0] hostAddr,
    output logic hostWrite,
    output logic hostRead,
    output logic [23:0] hostWrData
);
    logic [23:0] expQ[$];
    initial begin
        hostAddr = 9'h000;
        hostWrite = 1'b0;
        hostRead = 1'b0;
        hostWrData = 24'h000000;
    end
    // Launched after an edge, held through the sampling edge
    task automatic acc(input logic w, input logic [8:0] a,
        input logic [23:0] d);
        @(posedge ref_clk);
        hostAddr <= a;
        hostWrite <= w;
        hostRead <= !w;
        hostWrData <= d;
        @(posedge ref_clk);
        hostWrite <= 1'b0;
        hostRead <= 1'b0;
        hostAddr <= ~a;
        hostWrData <= ~d;
    endtask
    // The answer is noted before the read goes out
    task automatic rd(input logic [8:0] a, input logic [23:0] e);
        expQ.push_back(e);
        acc(1'b0, a, ~e);
    endtask
    // Three accesses to one address, low byte first
    task automatic wrb(input logic [8:0] a, input logic [23:0] d);
        for (int i = 0; i < 3; i++) begin
            acc(1'b1, a, {16'h0000, d[8*i+:8]});
        end
    endtask
    task automatic rdb(input logic [8:0] a, input logic [23:0] e);
        for (int i = 0; i < 3; i++) begin
            rd(a, {16'h0000, e[8*i+:8]});
        end
    endtask
endmodule // vch_host_model

// ==== tb/vch_host_reg_port_monitor.sv ====
`timescale 1ns/1ps
// Pin-level checks of the host port and pixel path
module vch_host_reg_port_monitor #(
    parameter int DP_COUNT = vch_pkg::DP_COUNT
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [8:0] hostAddr,
    input wire logic hostWrite,
    input wire logic hostRead,
    input wire logic [23:0] hostWrData,
    input wire logic [23:0] hostRdData,
    input wire logic hostRdValid,
    input wire logic pixelValid,
    input wire logic colourValid,
    input wire logic videoTimingEnable,
    input wire logic hostByteMode,
    input wire logic mode2Select,
    input wire logic [23:0] pllMultiplier,
    input wire logic bootWritten
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // Write wins, so a read only counts without a write
    logic rdReq, ctlWr;
    assign rdReq = hostRead && !hostWrite;
    assign ctlWr = hostWrite && !hostByteMode
        && hostAddr == vch_pkg::CTRL_ADDR;
    a_read_latency: assert property (rdReq |-> ##2 hostRdValid)
        else $error("read answer missing");
    a_no_spurious: assert property (hostRdValid |-> $past(rdReq, 2))
        else $error("read answer without request");
    a_unmapped_zero: assert property (rdReq && hostAddr ==
        vch_pkg::DP_BASE + 9'(DP_COUNT) |-> ##2 hostRdData == 24'h0)
        else $error("unmapped read not zero");
    a_byte_upper: assert property (hostRdValid
        && $past(hostByteMode, 2) |-> hostRdData[23:8] == 16'h0)
        else $error("byte read upper bits set");
    a_ctrl_fields: assert property (ctlWr |=>
        {hostByteMode, mode2Select, videoTimingEnable}
        == $past({hostWrData[7], hostWrData[1], hostWrData[0]}))
        else $error("control bits not taken");
    a_reset_state: assert property ($fell(sys_rst) |->
        !hostByteMode && !videoTimingEnable && !bootWritten)
        else $error("reset state wrong");
    a_boot_lock: assert property (bootWritten |=>
        bootWritten && $stable(pllMultiplier))
        else $error("boot value changed");
    a_boot_cause: assert property ($rose(bootWritten) |->
        $past(hostWrite && hostAddr == vch_pkg::BOOT_ADDR))
        else $error("boot taken without boot write");
    a_colour_lag: assert property (colourValid == $past(pixelValid))
        else $error("colour valid not one cycle late");
    cover property (hostByteMode && hostRdValid);
    cover property ($rose(bootWritten));
    cover property (colourValid && !mode2Select);
endmodule // vch_host_reg_port_monitor

bind vch_host_reg_port vch_host_reg_port_monitor #(.DP_COUNT(DP_COUNT))
    u_mon (.ref_clk(ref_clk), .sys_rst(sys_rst), .hostAddr(hostAddr),
    .hostWrite(hostWrite), .hostRead(hostRead), .hostWrData(hostWrData),
    .hostRdData(hostRdData), .hostRdValid(hostRdValid),
    .pixelValid(pixelValid), .colourValid(colourValid),
    .videoTimingEnable(videoTimingEnable), .hostByteMode(hostByteMode),
    .mode2Select(mode2Select), .pllMultiplier(pllMultiplier),
    .bootWritten(bootWritten));

// ==== tb/tb_video_ctrl_host_reg_port.sv ====
`timescale 1ns/1ps
// Self-checking bench for the host register port
module tb_video_ctrl_host_reg_port;
    localparam logic [8:0] CA = vch_pkg::CTRL_ADDR;
    localparam logic [8:0] DP = vch_pkg::DP_BASE;
    localparam logic [8:0] BA = vch_pkg::BOOT_ADDR;
    logic ref_clk, sys_rst, hostWrite, hostRead, hostRdValid, pixelValid;
    logic colourValid, videoTimingEnable, hostByteMode, mode2Select;
    logic bootWritten;
    logic [8:0] hostAddr;
    logic [7:0] pixelIn;
    logic [23:0] hostWrData, hostRdData, colourOut, pllMultiplier, q;
    logic [23:0] pixQ[$];
    logic [23:0] pv[4];
    logic [7:0] ix[4] = '{8'h00, 8'h0f, 8'h5a, 8'hff};
    int error_cnt = 0;
    int compares = 0;
    vch_host_reg_port u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .hostAddr(hostAddr), .hostWrite(hostWrite), .hostRead(hostRead),
        .hostWrData(hostWrData), .hostRdData(hostRdData),
        .hostRdValid(hostRdValid), .pixelIn(pixelIn),
        .pixelValid(pixelValid), .colourOut(colourOut),
        .colourValid(colourValid), .videoTimingEnable(videoTimingEnable),
        .hostByteMode(hostByteMode), .mode2Select(mode2Select),
        .pllMultiplier(pllMultiplier), .bootWritten(bootWritten));
    vch_host_model u_h (.ref_clk(ref_clk), .hostAddr(hostAddr),
        .hostWrite(hostWrite), .hostRead(hostRead),
        .hostWrData(hostWrData));
    task automatic chk(input string n, input logic [23:0] s,
        input logic [23:0] e);
        compares++;
        if (s !== e) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", n, e, s);
        end
    endtask
    task automatic finish_test();
        chk("reads left", 24'(u_h.expQ.size()), 24'h000000);
        chk("pixels left", 24'(pixQ.size()), 24'h000000);
        $display("compares %0d, mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // One pixel for one cycle; the input idles at the inverse
    task automatic px(input logic [7:0] p, input logic [23:0] e);
        pixQ.push_back(e);
        @(posedge ref_clk);
        pixelIn <= p;
        pixelValid <= 1'b1;
        @(posedge ref_clk);
        pixelValid <= 1'b0;
        pixelIn <= ~p;
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // Answers come back in request order, so the oldest note matches
    always @(posedge ref_clk) begin
        if (hostRdValid === 1'b1) begin
            chk("read note", 24'(u_h.expQ.size() != 0), 24'h000001);
            chk("read", hostRdData, u_h.expQ.pop_front());
        end
        if (colourValid === 1'b1) begin
            chk("colour note", 24'(pixQ.size() != 0), 24'h000001);
            if (pixQ.size() != 0) begin
                chk("colour", colourOut, pixQ.pop_front());
            end
        end
    end
    // A hang costs far more than the 120 or so cycles the run needs
    initial begin
        #50us;
        error_cnt++;
        finish_test();
    end
    initial begin
        void'($urandom(32'h038b3751));
        sys_rst = 1'b1;
        pixelIn = 8'h00;
        pixelValid = 1'b0;
        repeat (10) @(posedge ref_clk);
        sys_rst <= 1'b0;
        u_h.rd(CA, 24'h000000);
        // Boot takes the first write only
        u_h.acc(1'b1, BA, 24'h000021);
        u_h.acc(1'b1, BA, 24'h000055);
        @(negedge ref_clk);
        chk("boot", pllMultiplier, 24'h000021);
        chk("boot flag", {23'h0, bootWritten}, 24'h000001);
        foreach (pv[i]) begin
            pv[i] = 24'($urandom);
            u_h.acc(1'b1, {1'b0, ix[i]}, pv[i]);
        end
        foreach (pv[i]) u_h.rd({1'b0, ix[i]}, pv[i]);
        // Mode 1 masks the pixel, mode 2 bypasses the mask
        u_h.acc(1'b1, vch_pkg::MASK_ADDR, 24'h00000f);
        px(8'hff, pv[1]);
        px(8'h0f, pv[1]);
        u_h.acc(1'b1, CA, 24'h000002);
        px(8'hff, pv[3]);
        px(8'h5a, pv[2]);
        q = 24'($urandom) | 24'h000001;
        u_h.acc(1'b1, DP + 9'h00f, q);
        u_h.rd(DP + 9'h00f, q);
        u_h.rd(DP + 9'h010, 24'h000000);
        u_h.acc(1'b1, CA, 24'h000001);
        u_h.rd(CA, 24'h000001);
        @(negedge ref_clk);
        chk("timing on", {23'h0, videoTimingEnable}, 24'h000001);
        u_h.acc(1'b1, CA, 24'h000080);
        @(negedge ref_clk);
        chk("byte mode", {23'h0, hostByteMode}, 24'h000001);
        q = 24'($urandom);
        u_h.wrb(DP, q);
        u_h.rdb(DP, q);
        u_h.wrb({1'b0, ix[0]}, q);
        u_h.rdb({1'b0, ix[0]}, q);
        // Two bytes then a foreign access: the register keeps its value
        u_h.acc(1'b1, DP, 24'h0000aa);
        u_h.acc(1'b1, DP, 24'h0000bb);
        u_h.rd(CA, 24'h000080);
        u_h.rdb(DP, q);
        u_h.rd(DP, {16'h0000, q[7:0]});
        u_h.rd(CA, 24'h000080);
        u_h.rd(DP, {16'h0000, q[7:0]});
        // Second reset: control clears, palette survives, boot reopens
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        u_h.rd(CA, 24'h000000);
        u_h.rd({1'b0, ix[2]}, pv[2]);
        u_h.acc(1'b1, BA, 24'h000033);
        @(negedge ref_clk);
        chk("boot", pllMultiplier, 24'h000033);
        repeat (4) @(posedge ref_clk);
        finish_test();
    end
endmodule // tb_video_ctrl_host_reg_port
